// ### design/pps_pkg.sv
// Constants for the protection and sync block.
// Assumes a 200 MHz core clock and comparator flags as raw asynchronous levels.
package pps_pkg;
  localparam int CLK_PERIOD_PS      = 5000;
  // Short-circuit fault timer, in microseconds
  localparam int SC_FAULT_TIME_US   = 125000;
  localparam int SC_FAULT_CYCLES    = SC_FAULT_TIME_US * (1000000 / CLK_PERIOD_PS);
  // Least sync pulse width, in nanoseconds
  localparam int SYNC_MIN_PULSE_NS  = 500;
  localparam int SYNC_MIN_CYCLES    = (SYNC_MIN_PULSE_NS * 1000 + CLK_PERIOD_PS - 1)
                                      / CLK_PERIOD_PS;
  localparam int PERIOD_W           = 24;
  localparam int SC_CNT_W           = 26;
  localparam int SYNC_BITS          = 9;
  // Hiccup phases on the PWM supply
  typedef enum logic [1:0]
  {
    HIC_RUN    = 2'h0,
    HIC_FIRST  = 2'h1,
    HIC_SECOND = 2'h2,
    HIC_WAIT   = 2'h3
  } pps_hic_t;
endpackage : pps_pkg

// ### design/pps_top.sv
// Protection and synchronisation logic of the PFC/PWM controller.
// Assumes analog comparators deliver flags and ARST_N follows the supply reset.
// Operation
// R1: Sync falling crossings are clock events; their spacing sets switching period.
// R2: Sync source holds each pulse at least the minimum width.
// R3: Divided PWM gate drive may feed the PFC sync input.
// R4: Captured clock edge sets PFC drive only at zero current, then clears.
// R5: Overvoltage forces PFC gate low and control switch off, auto resume.
// R6: Undervoltage shuts the whole PFC section into low consumption.
// R7: Feedback pulled low or open reads as undervoltage.
// R8: Overcurrent forces PFC gate low; re-enable next clock if cleared.
// R9: Feedback above fault level for full timer declares short-circuit fault.
// R10: Fault disables PFC bias and runs PWM supply double hiccup.
// R11: Fault recovers when supply above start and feedback below threshold.
// R12: Current sense above limit ends the PWM on-pulse.
// R13: Current sense above latch level latches PWM off until supply reset.
// R14: All flags and sync pass two flip-flops before use; PFC_ON_TIME_DONE and both PWM supply flags are used unsynchronised.
`timescale 1ns/1ps
module pps_top
  import pps_pkg::*;
#(
  parameter int SC_CYCLES = pps_pkg::SC_FAULT_CYCLES
)
(
  input  wire logic                         CLOCK,
  input  wire logic                         ARST_N,
  input  wire logic                         SYNC_MODE,
  input  wire logic                         SYNC_IN,
  input  wire logic                         OSC_CLOCK,
  input  wire logic                         ZERO_CURRENT_DETECT,
  input  wire logic                         OVERVOLTAGE_GUARD,
  input  wire logic                         UNDERVOLTAGE_GUARD,
  input  wire logic                         OVERCURRENT_GUARD,
  input  wire logic                         PFC_ON_TIME_DONE,
  input  wire logic                         PWM_FB_ABOVE_FAULT,
  input  wire logic                         PWM_SUPPLY_ABOVE_START,
  input  wire logic                         PWM_SUPPLY_BELOW_STOP,
  input  wire logic                         PWM_CS_ABOVE_LIMIT,
  input  wire logic                         PWM_CS_ABOVE_LATCH,
  input  wire logic                         PWM_CLOCK_EVENT,
  output logic                              PFC_GATE_DRIVE,
  output logic                              PWM_GATE_DRIVE,
  output logic                              CONTROL_SWITCH_ON,
  output logic                              PFC_SHUTDOWN,
  output logic                              PFC_BIAS_ENABLE,
  output logic                              PWM_SUPPLY_CHARGE,
  output logic                              SC_FAULT,
  output logic                              PWM_LATCHED_OFF,
  output logic [pps_pkg::PERIOD_W-1:0]      SYNC_PERIOD,
  output logic                              SYNC_PERIOD_VALID
);
  import pps_pkg::*;

  logic [SYNC_BITS-1:0] meta_r;
  logic [SYNC_BITS-1:0] sync_r;
  logic [SYNC_BITS-1:0] raw_in;
  logic                 clk_src_d_r;
  logic                 edge_latch_r;
  logic                 pfc_drive_r;
  logic                 pwm_drive_r;
  logic                 pwm_latch_r;
  logic [SC_CNT_W-1:0]  sc_cnt_r;
  logic                 fault_r;
  pps_hic_t             hic_r;
  pps_hic_t             hic_nxt;
  logic [PERIOD_W-1:0]  per_cnt_r;
  logic [PERIOD_W-1:0]  period_r;
  logic                 per_valid_r;
  logic                 seen_edge_r;

  assign raw_in = {PWM_CLOCK_EVENT, PWM_CS_ABOVE_LATCH, PWM_CS_ABOVE_LIMIT,
                   PWM_FB_ABOVE_FAULT, OVERCURRENT_GUARD, UNDERVOLTAGE_GUARD,
                   OVERVOLTAGE_GUARD, ZERO_CURRENT_DETECT,
                   SYNC_MODE ? SYNC_IN : OSC_CLOCK};

  // R14: two-stage sync per flag
  genvar gi;
  generate
    for (gi = 0; gi < SYNC_BITS; gi++)
    begin : g_sync
      always_ff @(posedge CLOCK or negedge ARST_N)
      begin
        if (!ARST_N)
        begin
          meta_r[gi] <= 1'b0;
          sync_r[gi] <= 1'b0;
        end
        else
        begin
          meta_r[gi] <= raw_in[gi];
          sync_r[gi] <= meta_r[gi];
        end
      end
    end
  endgenerate

  wire clk_src   = sync_r[0];
  wire zero_cur  = sync_r[1];
  wire over_v    = sync_r[2];
  wire under_v   = sync_r[3];
  wire over_i    = sync_r[4];
  wire fb_fault  = sync_r[5];
  wire cs_limit  = sync_r[6];
  wire cs_latch  = sync_r[7];
  wire pwm_clk   = sync_r[8];
  // R1: falling crossing is the clock event
  wire clk_fall  = clk_src_d_r & ~clk_src;
  // R6: undervoltage holds PFC in shutdown
  // R7: open or pulled-low feedback shows as undervoltage
  wire pfc_off   = under_v | fault_r;
  // R4: set drive only at zero current
  wire pfc_set   = edge_latch_r & zero_cur & ~pfc_off & ~over_v & ~over_i;
  // R5: overvoltage forces gate low
  // R8: overcurrent forces gate low
  wire pfc_kill  = over_v | over_i | pfc_off | PFC_ON_TIME_DONE;
  // R12: limit ends the on-pulse
  // R13: latch level holds gate off
  wire pwm_kill  = cs_limit | cs_latch | pwm_latch_r | fault_r;
  wire sc_done   = (sc_cnt_r == SC_CNT_W'(SC_CYCLES - 1));

  always_ff @(posedge CLOCK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      clk_src_d_r  <= 1'b0;
      edge_latch_r <= 1'b0;
      pfc_drive_r  <= 1'b0;
    end
    else
    begin
      clk_src_d_r  <= clk_src;
      // R4: edge captured, cleared on set
      if (clk_fall)
        edge_latch_r <= 1'b1;
      else if (pfc_set)
        edge_latch_r <= 1'b0;
      // R8: resumes only at a later clock event
      if (pfc_kill)
        pfc_drive_r <= 1'b0;
      else if (pfc_set)
        pfc_drive_r <= 1'b1;
    end
  end

  // R1: period between successive falling edges
  always_ff @(posedge CLOCK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      per_cnt_r   <= '0;
      period_r    <= '0;
      per_valid_r <= 1'b0;
      seen_edge_r <= 1'b0;
    end
    else if (clk_fall)
    begin
      per_cnt_r   <= PERIOD_W'(1);
      seen_edge_r <= 1'b1;
      period_r    <= per_cnt_r;
      per_valid_r <= seen_edge_r;
    end
    else if (per_cnt_r != '1)
      per_cnt_r <= per_cnt_r + PERIOD_W'(1);
  end

  // R9: timer restarts when feedback drops
  always_ff @(posedge CLOCK or negedge ARST_N)
  begin
    if (!ARST_N)
      sc_cnt_r <= '0;
    else if (!fb_fault || fault_r)
      sc_cnt_r <= '0;
    else if (!sc_done)
      sc_cnt_r <= sc_cnt_r + SC_CNT_W'(1);
  end

  // R10: two discharge cycles of the supply, charge off until HIC_WAIT
  always_comb
  begin
    hic_nxt = hic_r;
    case (hic_r)
      HIC_RUN:
        if (sc_done && fb_fault)
          hic_nxt = HIC_FIRST;
      HIC_FIRST:
        if (PWM_SUPPLY_BELOW_STOP)
          hic_nxt = HIC_SECOND;
      HIC_SECOND:
        if (PWM_SUPPLY_BELOW_STOP)
          hic_nxt = HIC_WAIT;
      HIC_WAIT:
        // R11: self-recovery condition
        if (PWM_SUPPLY_ABOVE_START && !fb_fault)
          hic_nxt = HIC_RUN;
      default:
        hic_nxt = HIC_RUN;
    endcase
  end

  always_ff @(posedge CLOCK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      hic_r       <= HIC_RUN;
      fault_r     <= 1'b0;
      pwm_latch_r <= 1'b0;
      pwm_drive_r <= 1'b0;
    end
    else
    begin
      hic_r   <= hic_nxt;
      fault_r <= (hic_nxt != HIC_RUN);
      // R13: cleared only by supply reset
      if (cs_latch)
        pwm_latch_r <= 1'b1;
      if (pwm_kill)
        pwm_drive_r <= 1'b0;
      else if (pwm_clk)
        pwm_drive_r <= 1'b1;
    end
  end

  assign PFC_GATE_DRIVE    = pfc_drive_r;
  assign PWM_GATE_DRIVE    = pwm_drive_r;
  // R5: control switch held off
  assign CONTROL_SWITCH_ON = ~(over_v | pfc_off);
  assign PFC_SHUTDOWN      = pfc_off;
  // R10: bias removed during fault
  assign PFC_BIAS_ENABLE   = ~fault_r;
  assign PWM_SUPPLY_CHARGE = (hic_r == HIC_WAIT) | (hic_r == HIC_RUN);
  assign SC_FAULT          = fault_r;
  assign PWM_LATCHED_OFF   = pwm_latch_r;
  assign SYNC_PERIOD       = period_r;
  assign SYNC_PERIOD_VALID = per_valid_r;
endmodule : pps_top

// ### verification/pps_monitor.sv
// Checker on the top ports of the protection and sync block.
// Assumes flags under test are held for three clocks or more.
`timescale 1ns/1ps
module pps_monitor
(
  input wire logic CLOCK,
  input wire logic ARST_N,
  input wire logic OVERVOLTAGE_GUARD,
  input wire logic UNDERVOLTAGE_GUARD,
  input wire logic OVERCURRENT_GUARD,
  input wire logic PWM_CS_ABOVE_LIMIT,
  input wire logic PWM_CS_ABOVE_LATCH,
  input wire logic PFC_GATE_DRIVE,
  input wire logic PWM_GATE_DRIVE,
  input wire logic CONTROL_SWITCH_ON,
  input wire logic PFC_SHUTDOWN,
  input wire logic PFC_BIAS_ENABLE,
  input wire logic PWM_SUPPLY_CHARGE,
  input wire logic SC_FAULT,
  input wire logic PWM_LATCHED_OFF
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!ARST_N);
  overvolt_gate_a: assert property
    (OVERVOLTAGE_GUARD[*3] |=> !PFC_GATE_DRIVE && !CONTROL_SWITCH_ON) else $error("overvolt gate");
  undervolt_shut_a: assert property
    (UNDERVOLTAGE_GUARD[*3] |=> PFC_SHUTDOWN && !PFC_GATE_DRIVE) else $error("undervolt shut");
  overcurrent_gate_a: assert property
    (OVERCURRENT_GUARD[*3] |=> !PFC_GATE_DRIVE) else $error("overcurrent gate");
  pwm_limit_a: assert property
    (PWM_CS_ABOVE_LIMIT[*3] |=> !PWM_GATE_DRIVE) else $error("limit gate");
  latch_set_a: assert property
    (PWM_CS_ABOVE_LATCH[*3] |=> PWM_LATCHED_OFF) else $error("latch set");
  latch_hold_a: assert property
    (PWM_LATCHED_OFF |=> PWM_LATCHED_OFF) else $error("latch lost");
  latch_gate_a: assert property
    (PWM_LATCHED_OFF[*2] |-> !PWM_GATE_DRIVE) else $error("latched gate");
  fault_bias_a: assert property
    (SC_FAULT[*2] |-> !PFC_BIAS_ENABLE && !PFC_GATE_DRIVE) else $error("fault bias");
  fault_charge_a: assert property
    ($rose(SC_FAULT) |-> ##[0:2] !PWM_SUPPLY_CHARGE) else $error("fault charge");
  cover property (PFC_GATE_DRIVE);
  cover property ($rose(SC_FAULT));
  cover property ($rose(PWM_LATCHED_OFF));
endmodule : pps_monitor
bind pps_top pps_monitor pps_monitor_inst (.*);

// ### verification/pps_sync_source.sv
// Far-side model: external sync source on the sync comparator input.
// Assumes the bench clock; idles high so a stopped source makes no edges.
`timescale 1ns/1ps
module pps_sync_source #(parameter int PERIOD = 300)
(
  input  wire logic clock,
  input  wire logic enable,
  output logic      sync_in = 1'h1
);
  int cnt_r = 0;
  always @(negedge clock)
  begin
    cnt_r   <= enable ? (cnt_r + 1) % PERIOD : 0;
    sync_in <= !enable || (cnt_r < PERIOD / 2);
  end
endmodule : pps_sync_source

// ### verification/pps_tb_top.sv
// Bench: steps the flag inputs and checks gates, faults and sync period.
// Assumes the sync source model gives 300-clock periods when enabled.
`timescale 1ns/1ps
module pps_tb_top;
  import pps_pkg::*;
  logic                     clk = 1'h0;
  logic [11:0]              stim = 12'h000;
  wire logic [7:0]          outs;
  wire logic [PERIOD_W-1:0] per;
  wire logic                sin, vld;
  logic                     lock = 1'h0;
  wire logic                sync_pin;
  int                       miscompares = 0, samples_checked = 0;
  always #2.5 clk = ~clk;
  assign sync_pin = lock ? outs[1] : sin;
  pps_sync_source pps_sync_source_inst (.clock(clk), .enable(stim[1]), .sync_in(sin));
  pps_top #(.SC_CYCLES(50)) pps_top_inst (.CLOCK(clk), .ARST_N(stim[0]), .SYNC_MODE(stim[1]),
    .SYNC_IN(sync_pin), .OSC_CLOCK(1'h0), .ZERO_CURRENT_DETECT(stim[2]),
    .OVERVOLTAGE_GUARD(stim[3]),
    .UNDERVOLTAGE_GUARD(stim[4]), .OVERCURRENT_GUARD(stim[5]), .PFC_ON_TIME_DONE(1'h0),
    .PWM_FB_ABOVE_FAULT(stim[6]), .PWM_SUPPLY_ABOVE_START(stim[7]), .PWM_SUPPLY_BELOW_STOP(stim[8]),
    .PWM_CS_ABOVE_LIMIT(stim[9]), .PWM_CS_ABOVE_LATCH(stim[10]), .PWM_CLOCK_EVENT(stim[11]),
    .PFC_GATE_DRIVE(outs[0]), .PWM_GATE_DRIVE(outs[1]), .CONTROL_SWITCH_ON(outs[2]),
    .PFC_SHUTDOWN(outs[3]), .PFC_BIAS_ENABLE(outs[4]), .PWM_SUPPLY_CHARGE(outs[5]),
    .SC_FAULT(outs[6]), .PWM_LATCHED_OFF(outs[7]), .SYNC_PERIOD(per), .SYNC_PERIOD_VALID(vld));
  task automatic rep(input string nm, input logic [31:0] e, input logic [31:0] v);
    samples_checked++;
    if (v !== e)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, e, v);
    end
  endtask : rep
  // Inputs change by NBA on the falling edge, so no race with the source model
  task automatic step(input logic [11:0] s, input int n, input logic [7:0] m, input logic [7:0] e);
    stim <= s;
    repeat (n) @(negedge clk);
    if (m != 8'h00) rep("outputs", {24'h000000, e & m}, {24'h000000, outs & m});
  endtask : step
  task automatic complete_run;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : complete_run
  // Tests need about 2200 clocks; cut off at twice that
  initial
  begin
    #22us;
    miscompares++;
    complete_run;
  end
  // Stim bits: event latch limit stop start fb overcur undervolt overvolt zero mode rst_n
  initial
  begin
    step(12'h000, 16, 8'h31, 8'h30);
    step(12'h007, 700, 8'h01, 8'h01); // gate set
    rep("sync period", {8'h01, 24'h00012C}, {7'h00, vld, per}); // falling spacing
    step(12'h00F, 4, 8'h05, 8'h00); // overvoltage off
    step(12'h007, 4, 8'h04, 8'h04); // resume
    step(12'h017, 4, 8'h0C, 8'h08); // shutdown
    step(12'h027, 310, 8'h09, 8'h00); // gate held low
    step(12'h007, 310, 8'h01, 8'h01); // re-enabled
    step(12'h047, 40, 8'h40, 8'h00); // partial
    step(12'h007, 2, 8'h40, 8'h00); // restart
    step(12'h047, 45, 8'h40, 8'h00); // short span
    step(12'h047, 15, 8'h71, 8'h40); // fault
    step(12'h107, 1, 8'h00, 8'h00);
    step(12'h007, 3, 8'h60, 8'h40); // second hiccup
    step(12'h107, 1, 8'h00, 8'h00);
    step(12'h007, 3, 8'h60, 8'h60); // waiting
    step(12'h087, 5, 8'h50, 8'h10); // recovery
    step(12'h887, 2, 8'h00, 8'h00);
    step(12'h087, 3, 8'h02, 8'h02); // pulse on
    step(12'h287, 4, 8'h02, 8'h00); // limit
    lock <= 1'h1;
    repeat (3)
    begin
      step(12'h887, 2, 8'h00, 8'h00); // gate pulse start
      step(12'h087, 120, 8'h02, 8'h02); // gate high
      step(12'h287, 110, 8'h02, 8'h00); // gate cut
    end
    rep("locked period", {8'h01, 24'h0000E8}, {7'h00, vld, per}); // gate-driven sync
    lock <= 1'h0;
    step(12'h487, 4, 8'h80, 8'h80); // latch
    step(12'h887, 5, 8'h82, 8'h80); // held off
    step(12'h886, 3, 8'h80, 8'h00); // supply reset clears latch
    complete_run;
  end
endmodule : pps_tb_top
